// [common/sra_pkg.sv]
// Purpose: Shared constants and types for the serial register access block
// Assumes: 40-bit frames, 7-bit register address, 32-bit data
// Notes:   Access kinds are coded per register in a packed parameter map
`default_nettype none

package sra_pkg;

  localparam int FRAME_W  = 40;
  localparam int DIR_BIT  = 39;
  localparam int ADDR_HI  = 38;
  localparam int ADDR_LO  = 32;
  localparam int ADDR_W   = 7;
  localparam int DATA_W   = 32;
  localparam int NREG     = 128;
  localparam int WID_W    = 6;
  localparam int KIND_W   = 3;
  localparam int CNT_W    = 6;

  // Bit counter values in the link domain
  localparam logic [CNT_W-1:0]   CNT_RST   = 6'h00;
  localparam logic [CNT_W-1:0]   CNT_LAST  = 6'h27;
  localparam logic [CNT_W-1:0]   CNT_DONE  = 6'h28;

  localparam logic [FRAME_W-1:0] FRAME_RST = 40'h00_0000_0000;
  localparam logic [DATA_W-1:0]  REG_RST   = 32'h0000_0000;
  localparam logic [ADDR_W-1:0]  ADDR_RST  = 7'h00;
  localparam logic [WID_W-1:0]   WID_FULL  = 6'h20;

  // Register access kinds
  typedef enum logic [KIND_W-1:0] {
    SRA_ACC_RW = 3'h0,
    SRA_ACC_R  = 3'h1,
    SRA_ACC_RC = 3'h2,
    SRA_ACC_W  = 3'h3,
    SRA_ACC_WC = 3'h4
  } sra_acc_e;

  // Frame handling states, one-hot
  typedef enum logic [2:0] {
    SRA_ST_IDLE  = 3'b001,
    SRA_ST_FETCH = 3'b010,
    SRA_ST_APPLY = 3'b100
  } sra_state_e;

endpackage

`default_nettype wire

// [common/sra_frame_if.sv]
// Purpose: Carrier between the serial link engine and the register core
// Assumes: frame and reply are words that stay stable while read across domains
// Notes:   done_tgl flips once per completed 40-bit frame
`timescale 1ns/1ps
`default_nettype none

interface sra_frame_if;
  logic [sra_pkg::FRAME_W-1:0] frame;
  logic                        done_tgl;
  logic [sra_pkg::FRAME_W-1:0] reply;

  modport link (output frame, output done_tgl, input reply);
  modport core (input frame, input done_tgl, output reply);
endinterface

`default_nettype wire

// [hw/sra_spi_link.sv]
// Purpose: Serial shift engine on the link clock, 40-bit frames MSB first
// Assumes: Mode 3 style link, data in on rising edge, out on falling edge
// Notes:   Chip select high resets the shifter; a short frame is dropped
`timescale 1ns/1ps
`default_nettype none

module sra_spi_link (
  input  wire logic sclk_in,
  input  wire logic cs_n_in,
  input  wire logic nrst_in,
  input  wire logic mosi_in,
  output logic      miso_out,
  sra_frame_if.link lnk
);
  import sra_pkg::*;

  logic [CNT_W-1:0]   cnt_r;
  logic [FRAME_W-1:0] shift_r;
  logic               frm_rst_n;

  // Frame-scoped state ends with the frame's own select
  assign frm_rst_n = nrst_in & ~cs_n_in;

  always_ff @(posedge sclk_in or negedge frm_rst_n) begin
    if (!frm_rst_n) begin
      cnt_r   <= CNT_RST;
      shift_r <= FRAME_RST;
    end else if (cnt_r != CNT_DONE) begin
      shift_r <= {shift_r[FRAME_W-2:0], mosi_in}; // [R2]
      cnt_r   <= cnt_r + 6'h01;
    end
  end

  // Captured frame and toggle survive the select, read by the core domain
  always_ff @(posedge sclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      lnk.frame    <= FRAME_RST;
      lnk.done_tgl <= 1'b0;
    end else if (frm_rst_n && cnt_r == CNT_LAST) begin
      lnk.frame    <= {shift_r[FRAME_W-2:0], mosi_in}; // [R1]
      lnk.done_tgl <= ~lnk.done_tgl;
    end
  end

  // Reply bit 39 is always zero, so the select reset gives the first bit
  always_ff @(negedge sclk_in or negedge frm_rst_n) begin
    if (!frm_rst_n) begin
      miso_out <= 1'b0;
    end else if (cnt_r < CNT_DONE) begin
      miso_out <= lnk.reply[CNT_LAST - cnt_r]; // [R2]
    end
  end

endmodule // sra_spi_link

`default_nettype wire

// [hw/sra_top.sv]
// Purpose: Register bank reached over a 40-bit serial frame link
// Assumes: Link clock unrelated to ref_clk_in; host leaves gaps between frames
// Notes:   Reply of a frame carries the result of the previous frame
//
// Functional notes
// [R1] A frame is 40 bits: bit 39 direction, bits 38..32 address, bits 31..0 data.
// [R2] Frames shift most significant bit first, data bit 0 last.
// [R3] Direction one means write with data in the low word; zero means read.
// [R4] Narrow register values sit right aligned from bit 0 upward.
// [R5] Signed values are two's complement; bit groups are plain unsigned.
// [R6] All configuration is by register write, all access through the link.
// [R7] Clear-on-read registers return their content and then clear.
// [R8] Clear-on-write registers clear when a write addresses them.
// [R9] Read-only registers ignore writes; write-only registers read as zero.
// [R10] Data bits above a register's width are dropped on write, read as zero.
`timescale 1ns/1ps
`default_nettype none

module sra_top #(
  parameter logic [sra_pkg::NREG*sra_pkg::KIND_W-1:0] ACC_MAP   =
    {sra_pkg::NREG{sra_pkg::SRA_ACC_RW}},
  parameter logic [sra_pkg::NREG*sra_pkg::WID_W-1:0]  WIDTH_MAP =
    {sra_pkg::NREG{sra_pkg::WID_FULL}}
) (
  input  wire logic                        ref_clk_in,
  input  wire logic                        nrst_in,
  input  wire logic                        ce_in,
  input  wire logic                        spi_sclk_in,
  input  wire logic                        spi_cs_n_in,
  input  wire logic                        spi_mosi_in,
  output logic                             spi_miso_out,
  output logic                             spi_miso_oe_out,
  output logic                             wr_valid_out,
  output logic [sra_pkg::ADDR_W-1:0]       wr_addr_out,
  output logic [sra_pkg::DATA_W-1:0]       wr_data_out,
  output logic [sra_pkg::ADDR_W-1:0]       ro_addr_out,
  input  wire logic [sra_pkg::DATA_W-1:0]  ro_data_in,
  input  wire logic                        ev_valid_in,
  input  wire logic [sra_pkg::ADDR_W-1:0]  ev_addr_in,
  input  wire logic [sra_pkg::DATA_W-1:0]  ev_bits_in
);
  import sra_pkg::*;

  sra_frame_if frm ();

  logic [1:0]          rst_q;
  logic                rst_n;
  logic [1:0]          cs_sync_r;
  logic [2:0]          tgl_sync_r;
  logic                done_pulse;
  sra_state_e          state_r;
  logic                dir_r;
  logic [ADDR_W-1:0]   addr_r;
  logic [DATA_W-1:0]   wdata_r;
  logic [DATA_W-1:0]   ro_val_r;
  logic [FRAME_W-1:0]  reply_r;
  logic [DATA_W-1:0]   bank_r [NREG];
  sra_acc_e            kind;
  logic [DATA_W-1:0]   mask;
  logic [DATA_W-1:0]   ev_mask;
  sra_acc_e            ev_kind;
  logic [DATA_W-1:0]   rd_val;
  logic                ev_sticky;
  logic                do_clr;
  logic                do_store;

  // Width of register a as a low-bit mask
  function automatic logic [DATA_W-1:0] width_mask(input logic [ADDR_W-1:0] a);
    logic [WID_W-1:0]  w;
    logic [DATA_W:0]   m;
    w = WIDTH_MAP[a*WID_W +: WID_W];
    m = ({{DATA_W{1'b0}}, 1'b1} << w) - {{DATA_W{1'b0}}, 1'b1};
    return m[DATA_W-1:0];
  endfunction

  function automatic sra_acc_e kind_of(input logic [ADDR_W-1:0] a);
    return sra_acc_e'(ACC_MAP[a*KIND_W +: KIND_W]);
  endfunction

  // Reset release through two flops
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_q <= 2'b00;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  sra_spi_link u_link (
    .sclk_in  (spi_sclk_in),
    .cs_n_in  (spi_cs_n_in),
    .nrst_in  (nrst_in),
    .mosi_in  (spi_mosi_in),
    .miso_out (spi_miso_out),
    .lnk      (frm.link)
  );

  // Select level and frame-done toggle cross into the core clock
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      cs_sync_r  <= 2'b11;
      tgl_sync_r <= 3'b000;
    end else if (ce_in) begin
      cs_sync_r  <= {cs_sync_r[0], spi_cs_n_in};
      tgl_sync_r <= {tgl_sync_r[1:0], frm.done_tgl};
    end
  end
  assign done_pulse = tgl_sync_r[2] ^ tgl_sync_r[1];

  // Drive reply only inside a frame; lags select by the sync delay
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      spi_miso_oe_out <= 1'b0;
    end else if (ce_in) begin
      spi_miso_oe_out <= ~cs_sync_r[1];
    end
  end

  // Frame handling sequence
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= SRA_ST_IDLE;
    end else if (ce_in) begin
      case (state_r)
        SRA_ST_IDLE:  if (done_pulse) state_r <= SRA_ST_FETCH;
        SRA_ST_FETCH: state_r <= SRA_ST_APPLY;
        SRA_ST_APPLY: state_r <= SRA_ST_IDLE;
        default:      state_r <= SRA_ST_IDLE;
      endcase
    end
  end

  // Frame is stable in the link domain until the next frame completes
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      dir_r       <= 1'b0;
      addr_r      <= ADDR_RST;
      wdata_r     <= REG_RST;
      ro_addr_out <= ADDR_RST;
    end else if (ce_in && state_r == SRA_ST_IDLE && done_pulse) begin
      dir_r       <= frm.frame[DIR_BIT];            // [R1]
      addr_r      <= frm.frame[ADDR_HI:ADDR_LO];    // [R1]
      wdata_r     <= frm.frame[DATA_W-1:0];         // [R3]
      ro_addr_out <= frm.frame[ADDR_HI:ADDR_LO];
    end
  end

  // Read-only value taken one cycle after the address is presented
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ro_val_r <= REG_RST;
    end else if (ce_in && state_r == SRA_ST_FETCH) begin
      ro_val_r <= ro_data_in;
    end
  end

  assign kind    = kind_of(addr_r);
  assign mask    = width_mask(addr_r);
  assign ev_kind = kind_of(ev_addr_in);
  assign ev_mask = width_mask(ev_addr_in);

  // Hardware events accumulate only in sticky registers
  assign ev_sticky = ev_valid_in && (ev_kind == SRA_ACC_RC || ev_kind == SRA_ACC_WC);

  always_comb begin
    case (kind)
      SRA_ACC_RW: rd_val = bank_r[addr_r] & mask; // [R4]
      SRA_ACC_RC: rd_val = bank_r[addr_r] & mask;
      SRA_ACC_WC: rd_val = bank_r[addr_r] & mask;
      SRA_ACC_R:  rd_val = ro_val_r & mask;       // [R10]
      SRA_ACC_W:  rd_val = REG_RST;               // [R9]
      default:    rd_val = REG_RST;
    endcase
  end

  always_comb begin
    do_clr   = 1'b0;
    do_store = 1'b0;
    if (state_r == SRA_ST_APPLY) begin
      if (!dir_r && kind == SRA_ACC_RC) begin
        do_clr = 1'b1;                              // [R7]
      end
      if (dir_r && kind == SRA_ACC_WC) begin
        do_clr = 1'b1;                              // [R8]
      end
      if (dir_r && (kind == SRA_ACC_RW || kind == SRA_ACC_W)) begin
        do_store = 1'b1;                            // [R6]
      end
    end
  end

  // Register storage; a same-cycle event beats a clear
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NREG; i++) begin
        bank_r[i] <= REG_RST;
      end
    end else if (ce_in) begin
      if (ev_sticky) begin
        bank_r[ev_addr_in] <= bank_r[ev_addr_in] | (ev_bits_in & ev_mask);
      end
      if (do_clr) begin
        if (ev_sticky && ev_addr_in == addr_r) begin
          bank_r[addr_r] <= ev_bits_in & ev_mask;   // [R7]
        end else begin
          bank_r[addr_r] <= REG_RST;                // [R8]
        end
      end else if (do_store) begin
        bank_r[addr_r] <= wdata_r & mask;           // [R10]
      end
    end
  end

  // Reply for the next frame: zero flag, echoed address, content
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      reply_r <= FRAME_RST;
    end else if (ce_in && state_r == SRA_ST_APPLY) begin
      reply_r <= {1'b0, addr_r, rd_val};            // [R4]
    end
  end
  assign frm.reply = reply_r;

  // Write notice towards the application; read-only targets stay silent
  always_ff @(posedge ref_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      wr_valid_out <= 1'b0;
      wr_addr_out  <= ADDR_RST;
      wr_data_out  <= REG_RST;
    end else if (ce_in) begin
      wr_valid_out <= do_store;                     // [R9]
      if (do_store) begin
        wr_addr_out <= addr_r;
        wr_data_out <= wdata_r & mask;              // [R10]
      end
    end
  end

endmodule // sra_top

`default_nettype wire

// [verif/sra_chk.sv]
// Purpose: Port checks of the register link
// Assumes: One frame lasts far longer than 8 core clocks
// Notes:   Select reaches oe through a 2-3 clock sync lag
`timescale 1ns/1ps
`default_nettype none

module sra_chk #(
  parameter logic [sra_pkg::NREG*sra_pkg::KIND_W-1:0] ACC_MAP   = '0,
  parameter logic [sra_pkg::NREG*sra_pkg::WID_W-1:0]  WIDTH_MAP = '0
) (
  input  wire logic                       ref_clk_in,
  input  wire logic                       nrst_in,
  input  wire logic                       spi_cs_n_in,
  input  wire logic                       spi_miso_oe_out,
  input  wire logic                       wr_valid_out,
  input  wire logic [sra_pkg::ADDR_W-1:0] wr_addr_out,
  input  wire logic [sra_pkg::DATA_W-1:0] wr_data_out
);
  import sra_pkg::*;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);
  logic [KIND_W-1:0] kind;
  logic [WID_W-1:0]  wid;
  assign kind = ACC_MAP[wr_addr_out*KIND_W +: KIND_W];
  assign wid  = WIDTH_MAP[wr_addr_out*WID_W +: WID_W];

  a_oe_off: assert property (spi_cs_n_in [*5] |-> !spi_miso_oe_out)
    else $error("oe high while deselected");
  a_oe_on: assert property ((!spi_cs_n_in) [*5] |-> spi_miso_oe_out)
    else $error("oe low inside frame");
  a_oe_rise: assert property ($rose(spi_miso_oe_out) |-> !spi_cs_n_in)
    else $error("oe rose outside frame");
  a_oe_fall: assert property ($fell(spi_miso_oe_out) |-> spi_cs_n_in)
    else $error("oe fell inside frame");
  a_wr_gap: assert property (wr_valid_out |=> !wr_valid_out [*8])
    else $error("write pulses too close");
  a_wr_hold: assert property ($changed(wr_addr_out) || $changed(wr_data_out)
    |-> wr_valid_out)
    else $error("write outputs moved without pulse");
  a_wr_kind: assert property (wr_valid_out |-> kind inside {SRA_ACC_RW, SRA_ACC_W})
    else $error("write pulse for wrong kind");
  a_wr_width: assert property (wr_valid_out |-> (wr_data_out >> wid) == '0)
    else $error("write data above width");

  c_wr_full: cover property (wr_valid_out && wid == WID_FULL);
  c_wr_narrow: cover property (wr_valid_out && wid != WID_FULL);
  c_frame: cover property ($rose(spi_miso_oe_out));
endmodule // sra_chk

bind sra_top sra_chk #(.ACC_MAP(ACC_MAP), .WIDTH_MAP(WIDTH_MAP)) sra_chk_i (
  .ref_clk_in, .nrst_in, .spi_cs_n_in, .spi_miso_oe_out,
  .wr_valid_out, .wr_addr_out, .wr_data_out);

`default_nettype wire

// [verif/sra_host.sv]
// Purpose: Host side of the serial link
// Assumes: Idle-high link clock of 48 ns
// Notes:   Link clock stands still between frames
`timescale 1ns/1ps
`default_nettype none

module sra_host (
  output logic      sclk_out,
  output logic      cs_n_out,
  output logic      mosi_out,
  input  wire logic miso_in
);
  initial begin
    sclk_out = 1'b1;
    cs_n_out = 1'b1;
    mosi_out = 1'b0;
  end

  // Whole 40-bit frame only; reply bits taken on rising edges
  task automatic xfer(input logic [39:0] tx, output logic [39:0] rx);
    cs_n_out = 1'b0;
    #80;
    for (int i = 39; i >= 0; i--) begin
      sclk_out = 1'b0;
      mosi_out = tx[i];
      #24;
      sclk_out = 1'b1;
      rx[i] = miso_in;
      #24;
    end
    cs_n_out = 1'b1;
    // Released line must not look like held data
    mosi_out = ~mosi_out;
    #160;
  endtask
endmodule // sra_host

`default_nettype wire

// [verif/sra_top_tb.sv]
// Purpose: Scenario bench of the register link
// Assumes: Reply of a frame comes in the next frame
// Notes:   Map: 1 RW, 2 R, 3 RC, 4 W, 5 WC, 6 RW of 8 bits
`timescale 1ns/1ps
`default_nettype none

module sra_top_tb;
  import sra_pkg::*;
  localparam logic [NREG*KIND_W-1:0] AM = (384'h1 << 6) | (384'h2 << 9)
    | (384'h3 << 12) | (384'h4 << 15);
  localparam logic [NREG*WID_W-1:0]  WM = {NREG{WID_FULL}} & ~(768'h3F << 36)
    | (768'h8 << 36);
  localparam logic [DATA_W-1:0]      ROV = 32'hA5C3_0F96;
  logic              clk = 1'b0;
  logic              nrst = 1'b0;
  logic              evv = 1'b0;
  logic [ADDR_W-1:0] eva = 7'h00;
  logic [DATA_W-1:0] evb = 32'h0000_0000;
  wire logic         sclk, cs_n, mosi, miso_o, oe, wv;
  wire logic [ADDR_W-1:0] wa, roa;
  wire logic [DATA_W-1:0] wd;
  wire logic         miso;
  logic [ADDR_W-1:0] la;
  logic [DATA_W-1:0] ld;
  int                nw = 0;
  int                n0, cyc = 0;
  int                n_mismatch = 0;
  int                checked = 0;

  always #10 clk = ~clk;
  assign miso = oe ? miso_o : ~miso_o;

  sra_top #(.ACC_MAP(AM), .WIDTH_MAP(WM)) sra_top_i (
    .ref_clk_in(clk), .nrst_in(nrst), .ce_in(1'b1), .spi_sclk_in(sclk),
    .spi_cs_n_in(cs_n), .spi_mosi_in(mosi), .spi_miso_out(miso_o),
    .spi_miso_oe_out(oe), .wr_valid_out(wv), .wr_addr_out(wa),
    .wr_data_out(wd), .ro_addr_out(roa), .ro_data_in(ROV),
    .ev_valid_in(evv), .ev_addr_in(eva), .ev_bits_in(evb));
  sra_host sra_host_i (.sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi),
    .miso_in(miso));

  always @(posedge clk) begin
    cyc++;
    if (wv) begin
      nw++;
      la = wa;
      ld = wd;
    end
    if (cyc == 20000) begin
      n_mismatch++;
      tally_and_finish;
    end
  end

  task automatic cmp(input logic [39:0] got, input logic [39:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    logic [39:0] r;
    sra_host_i.xfer({1'b1, a, d}, r);
  endtask

  task automatic rd(input logic [6:0] a, input logic [31:0] e);
    logic [39:0] r;
    sra_host_i.xfer({1'b0, a, 32'h0}, r);
    sra_host_i.xfer(40'h0, r);
    cmp(r, {1'b0, a, e});
  endtask

  task automatic ev(input logic [6:0] a, input logic [31:0] b);
    @(posedge clk);
    evv <= 1'b1;
    eva <= a;
    evb <= b;
    @(posedge clk);
    evv <= 1'b0;
  endtask

  task automatic t_rw;
    n0 = nw;
    wr(7'h01, 32'h89AB_CDEF);
    cmp(40'(nw - n0), 40'h1);
    cmp({1'b0, la, ld}, 40'h0189_ABCD_EF);
    rd(7'h01, 32'h89AB_CDEF);
    wr(7'h01, 32'hFFFF_FFFE);
    rd(7'h01, 32'hFFFF_FFFE);
    $display("rw test done");
  endtask

  task automatic t_width;
    wr(7'h06, 32'hFFFF_FF5A);
    cmp({8'h00, ld}, 40'h5A);
    rd(7'h06, 32'h0000_005A);
    $display("width test done");
  endtask

  task automatic t_ro;
    n0 = nw;
    wr(7'h02, 32'hFFFF_FFFF);
    wr(7'h04, 32'h0000_1234);
    cmp(40'(nw - n0), 40'h1);
    rd(7'h02, ROV);
    rd(7'h04, 32'h0000_0000);
    $display("ro test done");
  endtask

  task automatic t_rc;
    ev(7'h03, 32'h0000_0011);
    ev(7'h03, 32'h0100_0000);
    rd(7'h03, 32'h0100_0011);
    rd(7'h03, 32'h0000_0000);
    $display("rc test done");
  endtask

  task automatic t_wc;
    n0 = nw;
    ev(7'h05, 32'h0000_0006);
    rd(7'h05, 32'h0000_0006);
    rd(7'h05, 32'h0000_0006);
    wr(7'h05, 32'hFFFF_FFFF);
    rd(7'h05, 32'h0000_0000);
    cmp(40'(nw - n0), 40'h0);
    $display("wc test done");
  endtask

  task automatic tally_and_finish;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    #7;
    t_rw;
    t_width;
    t_ro;
    t_rc;
    t_wc;
    tally_and_finish;
  end
endmodule // sra_top_tb

`default_nettype wire
